// >>> hdl/alu_flags.sv
// computes the alu result and arithmetic flags for one operation
`timescale 1ns/100ps
`default_nettype none
module alu_flags
   import core_regs_pkg::*;
(
   input wire alu_op_t op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic c_in_i,
   output logic [7:0] result_o,
   output logic z_o,
   output logic dc_o,
   output logic c_o,
   output logic upd_zdc_o,
   output logic upd_c_o
);
   logic [8:0] sum;
   logic [4:0] nib;
   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      result_o = a_i;
      c_o = c_in_i;
      dc_o = 1'b0;
      upd_zdc_o = 1'b0;
      upd_c_o = 1'b0;
      unique case (op_i)
         ALU_ADD: begin
            sum = {1'b0, a_i} + {1'b0, b_i};
            nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
            result_o = sum[7:0];
            c_o = sum[8];
            dc_o = nib[4];
            upd_zdc_o = 1'b1;
            upd_c_o = 1'b1;
         end
         ALU_SUB: begin
            // a - b as a + ~b + 1, carry out is the inverted borrow
            sum = {1'b0, a_i} + {1'b0, ~b_i} + 9'h001;
            nib = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + 5'h01;
            result_o = sum[7:0];
            c_o = sum[8];
            dc_o = nib[4];
            upd_zdc_o = 1'b1;
            upd_c_o = 1'b1;
         end
         ALU_RRF: begin
            result_o = {c_in_i, a_i[7:1]};
            c_o = a_i[0];
            upd_c_o = 1'b1;
         end
         ALU_RLF: begin
            result_o = {a_i[6:0], c_in_i};
            c_o = a_i[7];
            upd_c_o = 1'b1;
         end
         ALU_LOGIC: begin
            result_o = b_i;
            upd_zdc_o = 1'b1;
         end
         default: begin
            result_o = a_i;
         end
      endcase
      z_o = (result_o == 8'h00);
   end
endmodule : alu_flags
`default_nettype wire

// >>> hdl/core_regs_pkg.sv
// shared constants and types for the core status, option and pc block
package core_regs_pkg;
   localparam logic [4:0] STATUS_ADDR = 5'h03;
   localparam logic [4:0] PCL_ADDR = 5'h02;
   localparam int PC_W = 11;
   localparam logic [10:0] RESET_VECTOR = 11'h7ff;
   localparam logic [5:0] CFG_RESET = 6'h3f;
   localparam int CFG_SRC_BIT = 5;
   localparam int CFG_EDGE_BIT = 4;
   localparam int CFG_PSA_BIT = 3;
   localparam int ST_PAGE_LSB = 5;
   localparam int ST_WDX_BIT = 4;
   localparam int ST_PD_BIT = 3;
   localparam int ST_Z_BIT = 2;
   localparam int ST_DC_BIT = 1;
   localparam int ST_C_BIT = 0;
   localparam logic [2:0] PAGE_RESET = 3'h0;

   typedef enum logic [2:0] {
      ALU_NONE, ALU_ADD, ALU_SUB, ALU_RRF, ALU_RLF, ALU_LOGIC
   } alu_op_t;

   typedef enum logic [2:0] {
      PC_SEQ, PC_JUMP, PC_CALL, PC_WRITE_LOW, PC_HOLD
   } pc_op_t;

   typedef struct packed {
      logic [2:0] page;
      logic wdx;
      logic pd;
      logic z;
      logic dc;
      logic c;
   } status_t;

   typedef struct packed {
      logic src;
      logic edge_sel;
      logic prescaler_assign;
      logic [2:0] ratio;
   } cfg_t;
endpackage : core_regs_pkg

// >>> hdl/core_status_option_pc.sv
// core status register, write-only timer configuration and program counter
`timescale 1ns/100ps
`default_nettype none
module core_status_option_pc
   import core_regs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic por_i,
   input wire logic wdt_clear_i,
   input wire logic sleep_i,
   input wire logic wdt_timeout_i,
   input wire logic option_load_i,
   input wire logic [7:0] acc_i,
   input wire alu_op_t alu_op_i,
   input wire logic [7:0] alu_a_i,
   input wire logic [7:0] alu_b_i,
   input wire logic file_wr_i,
   input wire logic [4:0] file_addr_i,
   input wire logic [7:0] file_wdata_i,
   input wire logic jump_i,
   input wire logic call_i,
   input wire logic stall_i,
   input wire logic [8:0] insn_addr_i,
   input wire logic [7:0] call_addr_i,
   input wire logic ext_count_pin_i,
   input wire logic instr_clk_tick_i,
   output logic [7:0] file_rdata_o,
   output logic [7:0] alu_result_o,
   output logic [10:0] pc_o,
   output logic timer_tick_o,
   output logic wdt_tick_o
);
   status_t status_r;
   status_t status_nxt;
   cfg_t cfg_r;
   cfg_t cfg_nxt;
   logic pin_q_r;
   logic pin_q_nxt;
   logic [7:0] presc_r;
   logic [7:0] presc_nxt;
   logic [8:0] presc_ext;
   logic timer_tick_r;
   logic timer_tick_nxt;
   logic wdt_tick_r;
   logic wdt_tick_nxt;
   logic [7:0] result;
   logic z_new;
   logic dc_new;
   logic c_new;
   logic upd_zdc;
   logic upd_c;
   logic wr_status;
   logic wr_pcl;
   logic src_evt;
   logic [3:0] shift;
   pc_op_t pc_op;
   logic [7:0] pc_low;

   alu_flags u_alu (
      .op_i(alu_op_i),
      .a_i(alu_a_i),
      .b_i(alu_b_i),
      .c_in_i(status_r.c),
      .result_o(result),
      .z_o(z_new),
      .dc_o(dc_new),
      .c_o(c_new),
      .upd_zdc_o(upd_zdc),
      .upd_c_o(upd_c)
   );

   // status writes carry raw file_wdata_i into page, z, dc and c but not wdx or pd; status flag bits that the alu operation updates take the alu flags instead
   assign wr_status = file_wr_i && (file_addr_i == STATUS_ADDR);
   assign wr_pcl = file_wr_i && (file_addr_i == PCL_ADDR);

   always_comb begin
      status_nxt = status_r;
      if (wr_status) begin
         status_nxt.page = file_wdata_i[7:5];
         if (!upd_zdc) begin
            status_nxt.z = file_wdata_i[ST_Z_BIT];
            status_nxt.dc = file_wdata_i[ST_DC_BIT];
         end
         if (!upd_c) begin
            status_nxt.c = file_wdata_i[ST_C_BIT];
         end
      end
      if (upd_zdc) begin
         status_nxt.z = z_new;
         status_nxt.dc = dc_new;
      end
      if (upd_c) begin
         status_nxt.c = c_new;
      end
      if (wdt_timeout_i) begin
         status_nxt.wdx = 1'b0;
      end
      if (sleep_i) begin
         status_nxt.wdx = 1'b1;
         status_nxt.pd = 1'b0;
      end
      if (wdt_clear_i || por_i) begin
         status_nxt.wdx = 1'b1;
         status_nxt.pd = 1'b1;
      end
   end

   always_comb begin
      cfg_nxt = cfg_r;
      if (option_load_i) begin
         cfg_nxt = acc_i[5:0];
      end
   end

   // prescaler: source select, edge detect, then divide
   always_comb begin
      pin_q_nxt = ext_count_pin_i;
      if (cfg_r.src) begin
         src_evt = cfg_r.edge_sel ? (pin_q_r && !ext_count_pin_i)
                                  : (!pin_q_r && ext_count_pin_i);
      end else begin
         src_evt = instr_clk_tick_i;
      end
      presc_nxt = presc_r;
      timer_tick_nxt = 1'b0;
      wdt_tick_nxt = 1'b0;
      presc_ext = {1'b0, presc_r} + 9'h001;
      shift = cfg_r.prescaler_assign ? {1'b0, cfg_r.ratio} : ({1'b0, cfg_r.ratio} + 4'h1);
      if (cfg_r.prescaler_assign) begin
         // watchdog path counts the instruction tick as its stand-in source
         if (instr_clk_tick_i) begin
            if (shift == 4'h0 || presc_ext[shift[2:0]] && presc_ext[7:0] == (8'h01 << shift)) begin
               presc_nxt = 8'h00;
               wdt_tick_nxt = 1'b1;
            end else begin
               presc_nxt = presc_ext[7:0];
            end
         end
      end else if (src_evt) begin
         if (presc_ext == (9'h001 << shift)) begin
            presc_nxt = 8'h00;
            timer_tick_nxt = 1'b1;
         end else begin
            presc_nxt = presc_ext[7:0];
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         status_r <= '{page: PAGE_RESET, wdx: 1'b1, pd: 1'b1, z: 1'b0, dc: 1'b0, c: 1'b0};
         cfg_r <= CFG_RESET;
         pin_q_r <= 1'b0;
         presc_r <= 8'h00;
         timer_tick_r <= 1'b0;
         wdt_tick_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
         cfg_r <= cfg_nxt;
         pin_q_r <= pin_q_nxt;
         presc_r <= presc_nxt;
         timer_tick_r <= timer_tick_nxt;
         wdt_tick_r <= wdt_tick_nxt;
      end
   end

   always_comb begin
      if (jump_i) begin
         pc_op = PC_JUMP;
         pc_low = result;
      end else if (call_i) begin
         pc_op = PC_CALL;
         pc_low = call_addr_i;
      end else if (wr_pcl) begin
         pc_op = PC_WRITE_LOW;
         pc_low = file_wdata_i;
      end else if (stall_i) begin
         pc_op = PC_HOLD;
         pc_low = result;
      end else begin
         pc_op = PC_SEQ;
         pc_low = result;
      end
   end

   pc_unit u_pc (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .op_i(pc_op),
      .target_i(insn_addr_i),
      .low_i(pc_low),
      .page_i(status_r.page[1:0]),
      .pc_o(pc_o)
   );

   // configuration is write-only, so no file address returns it
   always_comb begin
      unique case (file_addr_i)
         STATUS_ADDR: file_rdata_o = status_r;
         PCL_ADDR: file_rdata_o = pc_o[7:0];
         default: file_rdata_o = 8'h00;
      endcase
   end
   assign alu_result_o = result;
   assign timer_tick_o = timer_tick_r;
   assign wdt_tick_o = wdt_tick_r;

   sequence opt_write_s;
      option_load_i ##0 rstn_i;
   endsequence
   option_copy_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      opt_write_s |=> cfg_r == $past(acc_i[5:0]))
      else $error("option load did not copy accumulator");
   cfg_reset_a: assert property (@(posedge clock_i)
      !rstn_i |=> cfg_r == CFG_RESET)
      else $error("configuration not set by reset");
   status_reset_a: assert property (@(posedge clock_i)
      !rstn_i |=> status_r.page == PAGE_RESET && pc_o == RESET_VECTOR)
      else $error("reset did not clear page or load vector");
   sleep_flags_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      sleep_i && !wdt_clear_i && !por_i |=> !status_r.pd && status_r.wdx)
      else $error("sleep flags wrong");
   timeout_flag_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      wdt_timeout_i && !sleep_i && !wdt_clear_i && !por_i |=> !status_r.wdx)
      else $error("time-out did not clear expiry flag");
   flag_block_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      wr_status && upd_c |=> status_r.c == $past(c_new))
      else $error("status write overrode carry");
   zero_flag_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      upd_zdc |=> status_r.z == ($past(result) == 8'h00))
      else $error("zero flag wrong");
   page_keep_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      pc_op == PC_SEQ && !wr_status |=> $stable(status_r.page))
      else $error("page bits moved on sequential step");
   pcl_map_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      wr_pcl && !jump_i && !call_i |=> pc_o[7:0] == $past(file_wdata_i))
      else $error("pc low byte write did not reach pc");
endmodule : core_status_option_pc
`default_nettype wire

// >>> hdl/pc_unit.sv
// program counter with sequential, jump, call and low byte write loads
`timescale 1ns/100ps
`default_nettype none
module pc_unit
   import core_regs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire pc_op_t op_i,
   input wire logic [8:0] target_i,
   input wire logic [7:0] low_i,
   input wire logic [1:0] page_i,
   output logic [10:0] pc_o
);
   logic [10:0] pc_r;
   logic [10:0] pc_nxt;
   always_comb begin
      pc_nxt = pc_r;
      unique case (op_i)
         PC_SEQ: pc_nxt = pc_r + 11'h001;
         PC_JUMP: pc_nxt = {page_i, target_i};
         PC_CALL, PC_WRITE_LOW: pc_nxt = {page_i, 1'b0, low_i};
         PC_HOLD: pc_nxt = pc_r;
         default: pc_nxt = pc_r;
      endcase
   end
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         pc_r <= RESET_VECTOR;
      end else begin
         pc_r <= pc_nxt;
      end
   end
   assign pc_o = pc_r;

   // a sequential step counts the whole 11-bit pc, so the page bits take the carry out of bit 8
   seq_step_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (op_i == PC_SEQ) |=> pc_o == $past(pc_o) + 11'h001)
      else $error("pc did not advance by one");
   jump_load_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (op_i == PC_JUMP) |=> pc_o == {$past(page_i), $past(target_i)})
      else $error("jump did not load target with page");
   call_load_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (op_i == PC_CALL || op_i == PC_WRITE_LOW) |=> (pc_o[8] == 1'b0)
      && pc_o[7:0] == $past(low_i) && pc_o[10:9] == $past(page_i))
      else $error("call or low write loaded pc wrongly");
endmodule : pc_unit
`default_nettype wire

// >>> tb/core_status_option_pc_bench.sv
// self-checking bench for the core status, option and pc block
`timescale 1ns/100ps
`default_nettype none
module core_status_option_pc_bench
   import core_regs_pkg::*;
;
   typedef struct {alu_op_t op; logic [7:0] a, b, res, st, mask;} alu_row_t;
   logic clock_i = 1'b0;
   logic rstn_i, por_i, wdt_clear_i, sleep_i, wdt_timeout_i, option_load_i;
   logic file_wr_i, jump_i, call_i, stall_i, ext_count_pin_i, instr_clk_tick_i;
   logic timer_tick_o, wdt_tick_o, pin_run;
   logic [7:0] acc_i, alu_a_i, alu_b_i, file_wdata_i, call_addr_i, file_rdata_o, alu_result_o;
   alu_op_t alu_op_i;
   logic [4:0] file_addr_i;
   logic [8:0] insn_addr_i;
   logic [10:0] pc_o;
   int bad_count, check_count, cycles, g, i;
   // carry chains from row to row; rotates see the carry left by the row before
   alu_row_t alu_rows[9] = '{
      '{ALU_ADD, 8'h0f, 8'h01, 8'h10, 8'h1a, 8'hff}, '{ALU_ADD, 8'hff, 8'h01, 8'h00, 8'h1f, 8'hff},
      '{ALU_SUB, 8'h05, 8'h05, 8'h00, 8'h1f, 8'hff}, '{ALU_SUB, 8'h10, 8'h01, 8'h0f, 8'h19, 8'hff},
      '{ALU_SUB, 8'h01, 8'h02, 8'hff, 8'h18, 8'hff}, '{ALU_RLF, 8'h81, 8'h00, 8'h02, 8'h19, 8'hff},
      '{ALU_RRF, 8'h02, 8'h00, 8'h81, 8'h18, 8'hff}, '{ALU_LOGIC, 8'h00, 8'h00, 8'h00, 8'h1c, 8'hfc},
      '{ALU_LOGIC, 8'h00, 8'h5a, 8'h5a, 8'h18, 8'hfc}};
   // {por, clear, sleep, timeout} and the status that follows
   logic [3:0] fl_in[6] = '{4'h2, 4'h1, 4'h4, 4'h1, 4'h8, 4'h3};
   logic [7:0] fl_st[6] = '{8'h17, 8'h07, 8'h1f, 8'h0f, 8'h1f, 8'h17};
   // {jump, call, pc low write, stall} and the pc that follows
   logic [3:0] pc_in[5] = '{4'hc, 4'h4, 4'h2, 4'h1, 4'h0};
   logic [10:0] pc_exp[5] = '{11'h323, 11'h2ab, 11'h234, 11'h234, 11'h235};
   logic [7:0] cfg_acc[7] = '{8'h00, 8'h03, 8'h0a, 8'h08, 8'h20, 8'h30, 8'hc6};
   // bit i belongs to row i: watchdog output for rows 2 and 3, count pin toggling for rows 4 and 5
   logic [6:0] cfg_w = 7'b0001100;
   logic [6:0] cfg_pin = 7'b0110000;
   int cfg_gap[7] = '{2, 16, 4, 1, 4, 4, 128};

   core_status_option_pc core_status_option_pc_inst (
      .clock_i(clock_i), .rstn_i(rstn_i), .por_i(por_i), .wdt_clear_i(wdt_clear_i),
      .sleep_i(sleep_i), .wdt_timeout_i(wdt_timeout_i), .option_load_i(option_load_i),
      .acc_i(acc_i), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i),
      .file_wr_i(file_wr_i), .file_addr_i(file_addr_i), .file_wdata_i(file_wdata_i),
      .jump_i(jump_i), .call_i(call_i), .stall_i(stall_i), .insn_addr_i(insn_addr_i),
      .call_addr_i(call_addr_i), .ext_count_pin_i(ext_count_pin_i),
      .instr_clk_tick_i(instr_clk_tick_i), .file_rdata_o(file_rdata_o),
      .alu_result_o(alu_result_o), .pc_o(pc_o), .timer_tick_o(timer_tick_o),
      .wdt_tick_o(wdt_tick_o));

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic step(input int n);
      repeat (n) @(negedge clock_i);
   endtask : step

   // cycles until the next tick of the chosen prescaler output
   task automatic gap(input logic w, output int n);
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while ((w ? wdt_tick_o : timer_tick_o) !== 1'b1 && n < 300);
   endtask : gap

   always @(negedge clock_i) if (pin_run) ext_count_pin_i <= ~ext_count_pin_i;

   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   initial begin
      {por_i, wdt_clear_i, sleep_i, wdt_timeout_i, option_load_i, file_wr_i} = '0;
      {jump_i, call_i, stall_i, ext_count_pin_i, pin_run, rstn_i} = '0;
      instr_clk_tick_i = 1'b1;
      {acc_i, alu_a_i, alu_b_i, file_wdata_i, call_addr_i} = '0;
      alu_op_i = ALU_NONE;
      file_addr_i = STATUS_ADDR;
      insn_addr_i = 9'h000;
      step(3);
      rstn_i = 1'b1;
      check(16'(pc_o), 16'h07ff, "reset pc");
      check(16'(file_rdata_o), 16'h0018, "reset status");
      for (i = 0; i < 9; i++) begin
         alu_op_i = alu_rows[i].op;
         alu_a_i = alu_rows[i].a;
         alu_b_i = alu_rows[i].b;
         #1 check(16'(alu_result_o), 16'(alu_rows[i].res), "alu result");
         step(1);
         check(16'(file_rdata_o & alu_rows[i].mask), 16'(alu_rows[i].st & alu_rows[i].mask),
            "alu flags");
      end
      $display("alu flags done");
      alu_op_i = ALU_NONE;
      file_wr_i = 1'b1;
      file_wdata_i = 8'he7;
      step(1);
      check(16'(file_rdata_o), 16'h00ff, "status write");
      alu_op_i = ALU_ADD;
      {alu_a_i, alu_b_i, file_wdata_i} = {8'hff, 8'h01, 8'h00};
      step(1);
      check(16'(file_rdata_o), 16'h001f, "blocked write");
      alu_op_i = ALU_NONE;
      file_wr_i = 1'b0;
      for (i = 0; i < 6; i++) begin
         {por_i, wdt_clear_i, sleep_i, wdt_timeout_i} = fl_in[i];
         step(1);
         check(16'(file_rdata_o), 16'(fl_st[i]), "reset flags");
      end
      {por_i, wdt_clear_i, sleep_i, wdt_timeout_i} = '0;
      $display("status flags done");
      {file_wr_i, file_wdata_i} = {1'b1, 8'h37};
      step(1);
      {file_wr_i, jump_i, insn_addr_i} = {1'b0, 1'b1, 9'h1ff};
      step(1);
      check(16'(pc_o), 16'h03ff, "jump page");
      jump_i = 1'b0;
      step(1);
      check(16'(pc_o), 16'h0400, "page cross");
      check(16'(file_rdata_o[7:5]), 16'h0001, "page kept");
      {file_addr_i, file_wdata_i, insn_addr_i, call_addr_i} = {PCL_ADDR, 8'h34, 9'h123, 8'hab};
      for (i = 0; i < 5; i++) begin
         {jump_i, call_i, file_wr_i, stall_i} = pc_in[i];
         step(1);
         check(16'(pc_o), 16'(pc_exp[i]), "pc load");
      end
      {jump_i, call_i, file_wr_i, stall_i} = '0;
      #1 check(16'(file_rdata_o), 16'h0035, "pc low read");
      $display("pc done");
      for (i = 0; i < 7; i++) begin
         {acc_i, option_load_i, pin_run} = {cfg_acc[i], 1'b1, cfg_pin[i]};
         step(1);
         option_load_i = 1'b0;
         gap(cfg_w[i], g);
         gap(cfg_w[i], g);
         check(16'(g), 16'(cfg_gap[i]), "tick gap");
      end
      $display("config done");
      {pin_run, file_addr_i, rstn_i} = {1'b0, STATUS_ADDR, 1'b0};
      step(1);
      rstn_i = 1'b1;
      check(16'(pc_o), 16'h07ff, "rerun pc");
      check(16'(file_rdata_o[7:5]), 16'h0000, "rerun page");
      gap(1'b1, g);
      gap(1'b1, g);
      check(16'(g), 16'd128, "reset config");
      $display("mid-run reset done");
      wrap_up();
   end
endmodule : core_status_option_pc_bench
`default_nettype wire
